// ==== logic/sgc_cfg.svh ====
// constants of the global switch control bank, offsets 0x06 to 0x0d
// assumes a 40 MHz core clock and byte-wide register access
`ifndef SGC_CFG_SVH
`define SGC_CFG_SVH

// ************************************************************
// register offsets
// ************************************************************
`define SGC_OFF_THR_HIGH 8'h06
`define SGC_OFF_THR_LOW 8'h07
`define SGC_OFF_TEST_A 8'h08
`define SGC_OFF_TEST_B 8'h09
`define SGC_OFF_TEST_C 8'h0a
`define SGC_OFF_OPTIONS 8'h0b
`define SGC_OFF_MAP_LOW 8'h0c
`define SGC_OFF_MAP_HIGH 8'h0d

// ************************************************************
// reset values and field positions
// ************************************************************
`define SGC_RST_THR_HIGH 3'h0
`define SGC_RST_THR_LOW 8'h63
`define SGC_RST_TEST_A 8'h00
`define SGC_RST_TEST_B 8'h24
`define SGC_RST_TEST_C 8'h35
`define SGC_RST_OPT_RSV_HI 2'h0
`define SGC_RST_OPT_RSV_MID 2'h2
`define SGC_RST_MAP_LOW 8'h50
`define SGC_RST_MAP_HIGH 8'hfa
`define SGC_BIT_LED_HI 7
`define SGC_BIT_TEST_MODE 4
`define SGC_BIT_LED_LO 1
`define SGC_BIT_TAG_MODE 0

// ************************************************************
// timing
// ************************************************************
`define SGC_CLK_KHZ 40000
`define SGC_FAST_PERIOD_MS 67
`define SGC_TEN_PERIOD_MS 500
`define SGC_FAST_PERIOD_CYC (`SGC_FAST_PERIOD_MS * `SGC_CLK_KHZ)
`define SGC_TEN_PERIOD_CYC (`SGC_TEN_PERIOD_MS * `SGC_CLK_KHZ)

`endif

// ==== logic/sgc_pkg.sv ====
// types of the global switch control bank
// assumes sgc_cfg.svh for all numbers
package sgc_pkg;
    typedef logic [7:0] sgc_byte_t;
    typedef logic [1:0] sgc_prio_t;
    typedef logic [2:0] sgc_pcp_t;
    typedef logic [10:0] sgc_thr_t;
    typedef logic [15:0] sgc_map_t;
    typedef logic [24:0] sgc_tick_t;
endpackage : sgc_pkg

// ==== logic/sgc_cfg_if.sv ====
// carrier of live configuration from the bank to its helpers
// assumes one clock domain
`timescale 1ns/1ps
interface sgc_cfg_if;
    sgc_pkg::sgc_thr_t thr;
    sgc_pkg::sgc_map_t prio_map;
    modport bank (output thr, output prio_map);
    modport storm (input thr);
    modport prio (input prio_map);
endinterface : sgc_cfg_if

// ==== logic/sgc_storm_meter.sv ====
// broadcast storm meter: period timer and block counter
// assumes one pulse per 64-byte block of broadcast data
`timescale 1ns/1ps
`include "sgc_cfg.svh"
module sgc_storm_meter #(
    parameter int P_FAST_CYC = `SGC_FAST_PERIOD_CYC,
    parameter int P_TEN_CYC = `SGC_TEN_PERIOD_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_fast_speed,
    input wire logic i_block,
    sgc_cfg_if.storm cfg,
    output logic o_allow,
    output logic o_period
);
    sgc_pkg::sgc_tick_t tick;
    sgc_pkg::sgc_thr_t used;
    logic wrap;

    assign wrap = i_fast_speed ? (tick >= 25'(P_FAST_CYC - 1))
                               : (tick >= 25'(P_TEN_CYC - 1));

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tick <= '0;
            o_period <= 1'b0;
        end else begin
            tick <= wrap ? '0 : tick + 25'h1;
            o_period <= wrap;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            used <= '0;
        end else if (wrap) begin
            used <= '0;
        end else if (i_block && used < cfg.thr) begin
            used <= used + 11'h1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_allow <= 1'b0;
        end else begin
            o_allow <= wrap ? (cfg.thr != '0) : (used < cfg.thr);
        end
    end
endmodule : sgc_storm_meter

// ==== logic/sgc_prio_mapper.sv ====
// 802.1p tag priority to internal priority lookup
// assumes tag valid and pcp come from same-clock parser logic
`timescale 1ns/1ps
module sgc_prio_mapper (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_tag_valid,
    input wire sgc_pkg::sgc_pcp_t i_pcp,
    sgc_cfg_if.prio cfg,
    output logic o_valid,
    output sgc_pkg::sgc_prio_t o_prio
);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_valid <= 1'b0;
            o_prio <= '0;
        end else begin
            o_valid <= i_tag_valid;
            if (i_tag_valid) begin
                o_prio <= cfg.prio_map[{i_pcp, 1'b0} +: 2];
            end
        end
    end
endmodule : sgc_prio_mapper

// ==== logic/sgc_global_ctrl.sv ====
// global control bank: storm threshold, factory bytes, led options,
// 802.1p priority map
// assumes a same-clock register master and strap pins from outside
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "sgc_cfg.svh"
module sgc_global_ctrl #(
    parameter int P_FAST_CYC = `SGC_FAST_PERIOD_CYC,
    parameter int P_TEN_CYC = `SGC_TEN_PERIOD_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_strap_led_hi,
    input wire logic i_strap_led_lo,
    input wire logic i_fast_speed,
    input wire logic i_bc_block,
    output logic o_bc_allow,
    output logic o_storm_period,
    input wire logic i_tag_valid,
    input wire logic [2:0] i_pcp,
    output logic o_prio_valid,
    output logic [1:0] o_int_prio,
    output logic [1:0] o_led_scheme,
    output logic o_direct_forward_tag_handling,
    output logic o_test_mode
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [2:0] thr_high;
    sgc_pkg::sgc_byte_t storm_threshold_low;
    sgc_pkg::sgc_byte_t factory_test_a;
    sgc_pkg::sgc_byte_t factory_test_b;
    sgc_pkg::sgc_byte_t factory_test_c;
    logic led_scheme_hi;
    logic led_scheme_lo;
    logic [1:0] opt_rsv_hi;
    logic test_mode;
    logic [1:0] opt_rsv_mid;
    logic direct_forward_tag_handling;
    sgc_pkg::sgc_byte_t priority_map_low_tags;
    sgc_pkg::sgc_byte_t priority_map_high_tags;
    sgc_pkg::sgc_byte_t next_rdata;
    sgc_pkg::sgc_byte_t options;

    // ************************************************************
    // strap synchronisers
    // ************************************************************
    logic strap_hi_meta;
    logic strap_hi_sync;
    logic strap_lo_meta;
    logic strap_lo_sync;
    logic strap_pending;

    // free running so the level seen during reset is ready at release
    always_ff @(posedge i_clk) begin
        strap_hi_meta <= i_strap_led_hi;
        strap_hi_sync <= strap_hi_meta;
    end

    always_ff @(posedge i_clk) begin
        strap_lo_meta <= i_strap_led_lo;
        strap_lo_sync <= strap_lo_meta;
    end

    // one-shot load of the led defaults after release
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            strap_pending <= 1'b1;
        end else begin
            strap_pending <= 1'b0;
        end
    end

    // ************************************************************
    // decode and packing helpers
    // ************************************************************
    // one strobe on one offset
    function automatic logic hit(input logic strobe, input logic [7:0] addr,
                                 input logic [7:0] offset);
        return strobe && (addr == offset);
    endfunction : hit

    // options byte, bit 7 down to bit 0
    function automatic sgc_pkg::sgc_byte_t pack_options(input logic led_hi,
                                                         input logic [1:0] rsv_hi,
                                                         input logic test,
                                                         input logic [1:0] rsv_mid,
                                                         input logic led_lo,
                                                         input logic tag);
        return {led_hi, rsv_hi, test, rsv_mid, led_lo, tag};
    endfunction : pack_options

    // ************************************************************
    // write decode
    // ************************************************************
    logic wr_thr_high;
    logic wr_thr_low;
    logic wr_test_a;
    logic wr_test_b;
    logic wr_test_c;
    logic wr_options;
    logic wr_map_low;
    logic wr_map_high;

    assign wr_thr_high = hit(i_wr, i_addr, `SGC_OFF_THR_HIGH);
    assign wr_thr_low = hit(i_wr, i_addr, `SGC_OFF_THR_LOW);
    assign wr_test_a = hit(i_wr, i_addr, `SGC_OFF_TEST_A);
    assign wr_test_b = hit(i_wr, i_addr, `SGC_OFF_TEST_B);
    assign wr_test_c = hit(i_wr, i_addr, `SGC_OFF_TEST_C);
    assign wr_options = hit(i_wr, i_addr, `SGC_OFF_OPTIONS);
    assign wr_map_low = hit(i_wr, i_addr, `SGC_OFF_MAP_LOW);
    assign wr_map_high = hit(i_wr, i_addr, `SGC_OFF_MAP_HIGH);

    // ************************************************************
    // storm threshold
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            thr_high <= `SGC_RST_THR_HIGH;
        end else if (wr_thr_high) begin
            thr_high <= i_wdata[2:0];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            storm_threshold_low <= `SGC_RST_THR_LOW;
        end else if (wr_thr_low) begin
            storm_threshold_low <= i_wdata;
        end
    end

    // ************************************************************
    // factory test bytes
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            factory_test_a <= `SGC_RST_TEST_A;
        end else if (wr_test_a) begin
            factory_test_a <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            factory_test_b <= `SGC_RST_TEST_B;
        end else if (wr_test_b) begin
            factory_test_b <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            factory_test_c <= `SGC_RST_TEST_C;
        end else if (wr_test_c) begin
            factory_test_c <= i_wdata;
        end
    end

    // ************************************************************
    // led and forwarding options
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            led_scheme_hi <= 1'b0;
        end else if (strap_pending) begin
            led_scheme_hi <= strap_hi_sync;
        end else if (wr_options) begin
            led_scheme_hi <= i_wdata[`SGC_BIT_LED_HI];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            led_scheme_lo <= 1'b0;
        end else if (strap_pending) begin
            led_scheme_lo <= strap_lo_sync;
        end else if (wr_options) begin
            led_scheme_lo <= i_wdata[`SGC_BIT_LED_LO];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            opt_rsv_hi <= `SGC_RST_OPT_RSV_HI;
        end else if (wr_options) begin
            opt_rsv_hi <= i_wdata[6:5];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            opt_rsv_mid <= `SGC_RST_OPT_RSV_MID;
        end else if (wr_options) begin
            opt_rsv_mid <= i_wdata[3:2];
        end
    end

    // stored as written; a one reaches the test mode output and bit 4 of the options byte
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            test_mode <= 1'b0;
        end else if (wr_options) begin
            test_mode <= i_wdata[`SGC_BIT_TEST_MODE];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            direct_forward_tag_handling <= 1'b0;
        end else if (wr_options) begin
            direct_forward_tag_handling <= i_wdata[`SGC_BIT_TAG_MODE];
        end
    end

    assign options = pack_options(led_scheme_hi, opt_rsv_hi, test_mode,
                                  opt_rsv_mid, led_scheme_lo, direct_forward_tag_handling);

    // ************************************************************
    // priority map
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            priority_map_low_tags <= `SGC_RST_MAP_LOW;
        end else if (wr_map_low) begin
            priority_map_low_tags <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            priority_map_high_tags <= `SGC_RST_MAP_HIGH;
        end else if (wr_map_high) begin
            priority_map_high_tags <= i_wdata;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    always_comb begin
        unique case (i_addr)
            `SGC_OFF_THR_HIGH: next_rdata = {5'h00, thr_high};
            `SGC_OFF_THR_LOW: next_rdata = storm_threshold_low;
            `SGC_OFF_TEST_A: next_rdata = factory_test_a;
            `SGC_OFF_TEST_B: next_rdata = factory_test_b;
            `SGC_OFF_TEST_C: next_rdata = factory_test_c;
            `SGC_OFF_OPTIONS: next_rdata = options;
            `SGC_OFF_MAP_LOW: next_rdata = priority_map_low_tags;
            `SGC_OFF_MAP_HIGH: next_rdata = priority_map_high_tags;
            default: next_rdata = 8'h00;
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ************************************************************
    // configuration outputs
    // ************************************************************
    assign o_led_scheme = {led_scheme_hi, led_scheme_lo};
    assign o_direct_forward_tag_handling = direct_forward_tag_handling;
    assign o_test_mode = test_mode;

    // ************************************************************
    // helpers
    // ************************************************************
    sgc_cfg_if cfg ();

    assign cfg.thr = {thr_high, storm_threshold_low};
    assign cfg.prio_map = {priority_map_high_tags, priority_map_low_tags};

    sgc_storm_meter #(
        .P_FAST_CYC(P_FAST_CYC),
        .P_TEN_CYC(P_TEN_CYC)
    ) u_storm (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_fast_speed(i_fast_speed),
        .i_block(i_bc_block),
        .cfg(cfg.storm),
        .o_allow(o_bc_allow),
        .o_period(o_storm_period)
    );

    sgc_prio_mapper u_prio (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_tag_valid(i_tag_valid),
        .i_pcp(i_pcp),
        .cfg(cfg.prio),
        .o_valid(o_prio_valid),
        .o_prio(o_int_prio)
    );

endmodule : sgc_global_ctrl

// ==== verification/sgc_global_ctrl_props.sv ====
// checker of the global control bank, watching the top ports only
// assumes a bind from the testbench top file
`timescale 1ns/1ps
module sgc_global_ctrl_props #(
    parameter int P_FAST_CYC = 20,
    parameter int P_TEN_CYC = 50
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_strap_led_hi,
    input wire logic i_strap_led_lo,
    input wire logic i_fast_speed,
    input wire logic i_bc_block,
    input wire logic o_bc_allow,
    input wire logic o_storm_period,
    input wire logic i_tag_valid,
    input wire logic [2:0] i_pcp,
    input wire logic o_prio_valid,
    input wire logic [1:0] o_int_prio,
    input wire logic [1:0] o_led_scheme,
    input wire logic o_direct_forward_tag_handling,
    input wire logic o_test_mode
);
    // ************************************************************
    // shadow of the priority map
    // ************************************************************
    logic [15:0] map_q;
    logic [1:0] exp_prio;
    logic live;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            map_q <= 16'hfa50;
        end else if (i_wr && i_addr == 8'h0c) begin
            map_q[7:0] <= i_wdata;
        end else if (i_wr && i_addr == 8'h0d) begin
            map_q[15:8] <= i_wdata;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            exp_prio <= 2'h0;
        end else if (i_tag_valid) begin
            exp_prio <= map_q[{i_pcp, 1'b0} +: 2];
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            live <= 1'b0;
        end else begin
            live <= 1'b1;
        end
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_rd_idle;
        !i_rd || i_addr < 8'h06 || i_addr > 8'h0d |=> o_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a mapped read");
    property p_prio_valid;
        i_tag_valid |=> o_prio_valid ##1 (o_prio_valid == $past(i_tag_valid));
    endproperty
    a_prio_valid: assert property (p_prio_valid)
        else $error("lookup valid pulse wrong");
    property p_prio_map;
        i_tag_valid && !i_wr |=> o_int_prio == exp_prio;
    endproperty
    a_prio_map: assert property (p_prio_map)
        else $error("internal priority not from selected field");
    property p_led_wr;
        i_wr && i_addr == 8'h0b |=> o_led_scheme == {$past(i_wdata[7]), $past(i_wdata[1])};
    endproperty
    a_led_wr: assert property (p_led_wr)
        else $error("led scheme not from bits 7 and 1");
    property p_flags_wr;
        i_wr && i_addr == 8'h0b |=> o_direct_forward_tag_handling == $past(i_wdata[0])
            && o_test_mode == $past(i_wdata[4]);
    endproperty
    a_flags_wr: assert property (p_flags_wr)
        else $error("option flags not from bits 0 and 4");
    property p_led_strap;
        $fell(i_rst) |=> o_led_scheme == {i_strap_led_hi, i_strap_led_lo};
    endproperty
    a_led_strap: assert property (p_led_strap)
        else $error("led scheme not loaded from straps");
    property p_allow_hold;
        live && !o_bc_allow && !i_wr && !$past(i_wr) |=> !o_bc_allow || o_storm_period;
    endproperty
    a_allow_hold: assert property (p_allow_hold)
        else $error("allow returned before period end");
    property p_allow_fall;
        $fell(o_bc_allow) |-> $past(i_bc_block) || $past(i_wr) || $past(i_wr, 2);
    endproperty
    a_allow_fall: assert property (p_allow_fall)
        else $error("allow fell without a block");
    property p_pulse_one;
        o_storm_period |=> !o_storm_period;
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("period pulse longer than one cycle");
endmodule : sgc_global_ctrl_props

// ==== verification/sgc_global_ctrl_test.sv ====
// self-checking bench of the global control bank
// assumes the bank, its checker and the 40 MHz clock made here
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("[ERR] %0t mismatch %h vs %h", $time, got, exp); end end
module sgc_global_ctrl_test;
    // ************************************************************
    // signals and model
    // ************************************************************
    logic i_clk, i_rst, i_wr, i_rd, i_strap_led_hi, i_strap_led_lo, i_fast_speed;
    logic i_bc_block, i_tag_valid, o_bc_allow, o_storm_period, o_prio_valid;
    logic o_direct_forward_tag_handling, o_test_mode;
    logic [7:0] i_addr, i_wdata, o_rdata;
    logic [2:0] i_pcp;
    logic [1:0] o_int_prio, o_led_scheme;
    logic [7:0] mdl [6:13];
    logic [31:0] r;
    int num_errors = 0;
    int samples_checked = 0;
    sgc_global_ctrl #(.P_FAST_CYC(20), .P_TEN_CYC(50)) sgc_global_ctrl_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_strap_led_hi(i_strap_led_hi),
        .i_strap_led_lo(i_strap_led_lo), .i_fast_speed(i_fast_speed),
        .i_bc_block(i_bc_block), .o_bc_allow(o_bc_allow), .o_storm_period(o_storm_period),
        .i_tag_valid(i_tag_valid), .i_pcp(i_pcp), .o_prio_valid(o_prio_valid),
        .o_int_prio(o_int_prio), .o_led_scheme(o_led_scheme),
        .o_direct_forward_tag_handling(o_direct_forward_tag_handling),
        .o_test_mode(o_test_mode));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic end_of_test();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        if (a >= 8'h06 && a <= 8'h0d) mdl[a] = (a == 8'h06) ? (d & 8'h07) : d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = (a >= 8'h06 && a <= 8'h0d) ? mdl[a] : 8'h00;
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        `CHK(o_rdata, e)
    endtask : rd
    task automatic check_all();
        for (int a = 5; a <= 15; a++) rd(a[7:0]);
        rd(8'hff);
    endtask : check_all
    task automatic do_reset(input logic hi, input logic lo);
        i_rst <= 1'b1;
        i_strap_led_hi <= hi;
        i_strap_led_lo <= lo;
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        mdl = '{8'h00, 8'h63, 8'h00, 8'h24, 8'h35, 8'h00, 8'h50, 8'hfa};
        mdl[11] = {hi, 2'b00, 1'b0, 2'b10, lo, 1'b0};
        @(negedge i_clk);
        `CHK(o_led_scheme, {hi, lo})
        `CHK(o_direct_forward_tag_handling, 1'b0)
    endtask : do_reset
    task automatic prio_sweep();
        logic [15:0] m;
        m = {mdl[13], mdl[12]};
        for (int p = 0; p < 8; p++) begin
            @(posedge i_clk);
            i_tag_valid <= 1'b1;
            i_pcp <= p[2:0];
            @(negedge i_clk);
            if (p > 0) `CHK(o_int_prio, m[2*p-2 +: 2])
        end
        @(posedge i_clk);
        i_tag_valid <= 1'b0;
        @(negedge i_clk);
        `CHK(o_int_prio, m[15:14])
        `CHK(o_prio_valid, 1'b1)
    endtask : prio_sweep
    task automatic wait_pulse(output int n);
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
            if (n > 200) begin
                num_errors++;
                end_of_test();
            end
        end while (o_storm_period !== 1'b1);
    endtask : wait_pulse
    task automatic storm(input logic [2:0] hi, input logic [7:0] lo, input logic fast);
        int thr;
        int n;
        thr = {hi, lo};
        wr(8'h06, {5'h00, hi});
        wr(8'h07, lo);
        i_fast_speed <= fast;
        wait_pulse(n);
        wait_pulse(n);
        `CHK(n, fast ? 20 : 50)
        for (int k = 1; k <= 6; k++) begin
            @(posedge i_clk);
            i_bc_block <= (k <= 5);
            @(negedge i_clk);
            `CHK(o_bc_allow, (thr != 0) && (k - 2 < thr))
        end
        wait_pulse(n);
        `CHK(o_bc_allow, (thr != 0))
    endtask : storm
    // ************************************************************
    // clock and main sequence
    // ************************************************************
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        {i_rst, i_wr, i_rd, i_strap_led_hi, i_strap_led_lo, i_fast_speed} = 6'h21;
        {i_bc_block, i_tag_valid, i_addr, i_wdata, i_pcp} = 21'h0;
        r = $urandom(31976);
        r = $urandom;
        do_reset(r[0], r[1]);
        check_all();
        prio_sweep();
        for (int a = 6; a <= 15; a++) begin
            r = $urandom;
            if (a >= 8 && a <= 10) r[7:0] = mdl[a];
            if (a == 11) r[4] = 1'b0;
            wr(a[7:0], r[7:0]);
        end
        check_all();
        `CHK(o_led_scheme, {mdl[11][7], mdl[11][1]})
        `CHK(o_test_mode, mdl[11][4])
        `CHK(o_direct_forward_tag_handling, mdl[11][0])
        prio_sweep();
        storm(3'h0, 8'h03, 1'b1);
        storm(3'h1, 8'h00, 1'b0);
        storm(3'h0, 8'h00, 1'b1);
        r = $urandom;
        do_reset(r[0], ~r[0]);
        check_all();
        end_of_test();
    end
endmodule : sgc_global_ctrl_test
bind sgc_global_ctrl sgc_global_ctrl_props #(.P_FAST_CYC(P_FAST_CYC), .P_TEN_CYC(P_TEN_CYC))
    sgc_global_ctrl_props_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_strap_led_hi(i_strap_led_hi),
    .i_strap_led_lo(i_strap_led_lo), .i_fast_speed(i_fast_speed), .i_bc_block(i_bc_block),
    .o_bc_allow(o_bc_allow), .o_storm_period(o_storm_period), .i_tag_valid(i_tag_valid),
    .i_pcp(i_pcp), .o_prio_valid(o_prio_valid), .o_int_prio(o_int_prio),
    .o_led_scheme(o_led_scheme), .o_test_mode(o_test_mode),
    .o_direct_forward_tag_handling(o_direct_forward_tag_handling));
